// file: eq_mode_pkg.sv
// Package: command layout, register selects, field positions and reset values
`default_nettype none
package eq_mode_pkg;

  // Register select codes carried by a mode register set command
  localparam logic [3:0] SEL_VREF_LEVEL = 4'h6;
  localparam logic [3:0] SEL_FEATURE = 4'h7;
  localparam logic [3:0] SEL_FEEDBACK_EQ = 4'h9;

  // Pin counts: eight data pins plus one inversion flag per byte
  localparam int PINS_PER_BYTE = 9;
  localparam int PIN_COUNT = 18;
  localparam int BYTE_COUNT = 2;

  // Field widths and positions within the 12-bit operand
  localparam int VREF_W = 7;
  localparam int FEQ_W = 4;
  localparam int TXEQ_W = 2;
  localparam int SUBADDR_MSB = 11;
  localparam int SUBADDR_LSB = 7;
  localparam int VREF_MSB = 6;
  localparam int FEQ_MSB = 3;
  localparam int TXEQ_MSB = 1;

  // Low four bits of the pin sub-address
  localparam logic [3:0] SUB_INV_FLAG = 4'h8;
  localparam logic [3:0] SUB_TXEQ = 4'hA;
  localparam logic [3:0] SUB_BROADCAST = 4'hF;

  // Feature register bit positions
  localparam int FEAT_HIBERNATE = 1;
  localparam int FEAT_LOW_FREQ = 3;
  localparam int FEAT_AUTO_SYNC = 4;
  localparam int FEAT_PREAMBLE = 5;
  localparam int FEAT_HALF_CMD_REF = 6;
  localparam int FEAT_HALF_DATA_REF = 7;

  // Reset values
  localparam logic [6:0] VREF_RESET = 7'h00;
  localparam logic [3:0] FEQ_RESET = 4'h0;
  localparam logic [1:0] TXEQ_RESET = 2'h0;

  // Level codes with both top bits set carry no level
  localparam logic [1:0] VREF_UNDEFINED_TOP = 2'h3;

  // Preamble: 8 unit intervals, two unit intervals per system clock
  localparam int PREAMBLE_UI = 8;
  localparam int UI_PER_CYCLE = 2;
  localparam int PREAMBLE_CYCLES = (PREAMBLE_UI + UI_PER_CYCLE - 1) / UI_PER_CYCLE;
  localparam int PREAMBLE_CNT_W = 3;

  typedef struct packed {
    logic valid;
    logic [3:0] select;
    logic [11:0] operand;
  } mrs_cmd_s;

  typedef struct packed {
    logic hibernate_armed;
    logic low_frequency_select;
    logic auto_sync;
    logic read_preamble_enable;
    logic half_command_ref;
    logic half_data_ref;
  } feature_s;

endpackage
`default_nettype wire

// file: read_preamble_gen.sv
// Read preamble window generator for non-gapless read bursts
`default_nettype none
module read_preamble_gen (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Control
  input wire logic enable_in,
  input wire logic burst_start_in,
  input wire logic gapless_in,
  // Preamble pins
  output logic active_out,
  output logic inv_flag_n_out
);

  localparam logic [2:0] LAST_COUNT = 3'(eq_mode_pkg::PREAMBLE_CYCLES - 1);

  logic [eq_mode_pkg::PREAMBLE_CNT_W-1:0] count;
  logic [eq_mode_pkg::PREAMBLE_CNT_W-1:0] next_count;
  logic next_active;
  wire start = enable_in & burst_start_in & ~gapless_in;
  wire done = active_out & (count == LAST_COUNT);

  // A new non-gapless burst restarts the window
  assign next_active = start | (active_out & ~done);
  assign next_count = start ? 3'h0 : (active_out ? count + 3'h1 : count);

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      active_out <= 1'b0;
      count <= 3'h0;
      inv_flag_n_out <= 1'b1;
    end else begin
      active_out <= next_active;
      count <= next_count;
      // Never inversion-encoded: the flag pins hold high for the window
      inv_flag_n_out <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// file: receiver_eq_mode_registers.sv
// Mode register decode and storage: reference levels, feedback eq, features
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Function
// - Select 0110 writes the per-pin input reference level register.
// - Select 1001 writes the per-pin feedback equalizer register.
// - Select 0111 writes the feature control register.
// - Both per-pin registers take a 5-bit pin sub-address from operand 11..7.
// - Level code from operand 6..0 goes to the addressed data or flag pin.
// - Sub-addresses 01111 and 11111 broadcast the level to a whole byte.
// - Level sub-addresses 01010 and 11010 store transmit equalizer bits 1..0.
// - Equalizer code from operand 3..0 stored per pin; zero means off.
// - Equalizer sub-addresses 01111 and 11111 broadcast to a whole byte.
// - Stored result does not depend on the order of per-pin writes.
// - Feature bit 7 forces half supply reference; clearing restores stored codes.
// - Feature bit 6 selects command reference half supply; resets to zero.
// - Feature bit 1 arms hibernate for next self refresh entry, then clears.
// - Feature bit 3 selects low frequency operation below 2GHz.
// - Feature bit 4 reduces clock alignment training to two writes.
// - Feature bit 5 adds 8 UI preamble before non-gapless read bursts.
// - Preamble not inversion-encoded; inversion pins held high during it.
module receiver_eq_mode_registers (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Decoded command bus
  input wire eq_mode_pkg::mrs_cmd_s mrs_cmd_in,
  input wire logic self_refresh_entry_in,
  // Read path
  input wire logic read_burst_start_in,
  input wire logic read_burst_gapless_in,
  input wire logic read_inversion_in,
  // Stored per-pin and per-byte settings, pin 0 and byte 0 in the low bits
  output logic [125:0] vref_level_out,
  output logic [71:0] feedback_eq_out,
  output logic [3:0] transmit_eq_out,
  // Effective data input reference
  output logic half_data_ref_out,
  output logic [125:0] data_input_reference_out,
  output logic [71:0] feedback_equalizer_out,
  // Feature state
  output eq_mode_pkg::feature_s feature_out,
  output logic hibernate_entry_out,
  output logic undefined_level_out,
  // Read preamble
  output logic preamble_active_out,
  output logic preamble_inv_flag_n_out
);

  //////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Pins addressed by a sub-address; empty for reserved codes
  function automatic logic [17:0] pin_mask(input logic [4:0] sub);
    logic [17:0] mask;
    logic [17:0] byte_bits;
    mask = 18'h0_0000;
    byte_bits = sub[4] ? 18'h3_FE00 : 18'h0_01FF;
    case (sub[3:0])
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
        mask = 18'h0_0001 << (sub[4] ? 5'(sub[2:0]) + 5'd9 : 5'(sub[2:0]));
      end
      eq_mode_pkg::SUB_INV_FLAG: begin
        mask = 18'h0_0100 << (sub[4] ? 5'd9 : 5'd0);
      end
      eq_mode_pkg::SUB_BROADCAST: begin
        mask = byte_bits;
      end
      default: begin
        // Reserved codes and the transmit eq slot reach no pin
        mask = 18'h0_0000;
      end
    endcase
    return mask;
  endfunction

  // Write enable per byte for the transmit equalizer field
  function automatic logic [1:0] txeq_mask(input logic [4:0] sub);
    logic [1:0] mask;
    mask = 2'h0;
    case (sub)
      {1'b0, eq_mode_pkg::SUB_TXEQ}: begin
        mask = 2'h1;
      end
      {1'b1, eq_mode_pkg::SUB_TXEQ}: begin
        mask = 2'h2;
      end
      default: begin
        mask = 2'h0;
      end
    endcase
    return mask;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Command decode

  wire cmd_valid = mrs_cmd_in.valid;
  wire [3:0] cmd_sel = mrs_cmd_in.select;
  wire [11:0] cmd_op = mrs_cmd_in.operand;

  wire vref_write = cmd_valid & (cmd_sel == eq_mode_pkg::SEL_VREF_LEVEL);
  wire feq_write = cmd_valid & (cmd_sel == eq_mode_pkg::SEL_FEEDBACK_EQ);
  wire feat_write = cmd_valid & (cmd_sel == eq_mode_pkg::SEL_FEATURE);

  wire [4:0] sub_addr =
    cmd_op[eq_mode_pkg::SUBADDR_MSB:eq_mode_pkg::SUBADDR_LSB];
  wire [6:0] level_code = cmd_op[eq_mode_pkg::VREF_MSB:0];
  wire [3:0] feq_code = cmd_op[eq_mode_pkg::FEQ_MSB:0];
  wire [1:0] txeq_code = cmd_op[eq_mode_pkg::TXEQ_MSB:0];

  wire [17:0] addr_pins = pin_mask(sub_addr);
  wire [17:0] vref_pin_we = vref_write ? addr_pins : 18'h0_0000;
  // Transmit eq codes live only in the level register's sub-address space
  wire [17:0] feq_pin_we = feq_write ? addr_pins : 18'h0_0000;
  wire [1:0] txeq_we = vref_write ? txeq_mask(sub_addr) : 2'h0;

  //////////////////////////////////////////////////////////////////////////////
  // Per-pin storage
  // Each pin only ever holds its last written code, so write order is free.

  logic [6:0] vref_code [eq_mode_pkg::PIN_COUNT];
  logic [3:0] feq_code_q [eq_mode_pkg::PIN_COUNT];
  logic [6:0] next_vref [eq_mode_pkg::PIN_COUNT];
  logic [3:0] next_feq [eq_mode_pkg::PIN_COUNT];

  genvar p;
  generate
    for (p = 0; p < eq_mode_pkg::PIN_COUNT; p++) begin : g_pin
      assign next_vref[p] = vref_pin_we[p] ? level_code : vref_code[p];
      assign next_feq[p] = feq_pin_we[p] ? feq_code : feq_code_q[p];

      always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
          vref_code[p] <= eq_mode_pkg::VREF_RESET;
        end else begin
          vref_code[p] <= next_vref[p];
        end
      end

      always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
          feq_code_q[p] <= eq_mode_pkg::FEQ_RESET;
        end else begin
          feq_code_q[p] <= next_feq[p];
        end
      end

      // Output copies keep the ports straight off flip-flops
      always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
          vref_level_out[p*7 +: 7] <= eq_mode_pkg::VREF_RESET;
        end else begin
          vref_level_out[p*7 +: 7] <= next_vref[p];
        end
      end

      always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
          feedback_eq_out[p*4 +: 4] <= eq_mode_pkg::FEQ_RESET;
        end else begin
          feedback_eq_out[p*4 +: 4] <= next_feq[p];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Transmit equalizer per byte

  logic [1:0] txeq_q [eq_mode_pkg::BYTE_COUNT];
  logic [1:0] next_txeq [eq_mode_pkg::BYTE_COUNT];

  genvar b;
  generate
    for (b = 0; b < eq_mode_pkg::BYTE_COUNT; b++) begin : g_byte
      assign next_txeq[b] = txeq_we[b] ? txeq_code : txeq_q[b];

      always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
          txeq_q[b] <= eq_mode_pkg::TXEQ_RESET;
        end else begin
          txeq_q[b] <= next_txeq[b];
        end
      end

      always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
          transmit_eq_out[b*2 +: 2] <= eq_mode_pkg::TXEQ_RESET;
        end else begin
          transmit_eq_out[b*2 +: 2] <= next_txeq[b];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Feature control register
  // Only the six defined bits are stored; the zero-fixed bits are dropped.

  eq_mode_pkg::feature_s feature_q;
  eq_mode_pkg::feature_s next_feature;
  eq_mode_pkg::feature_s written_feature;

  assign written_feature.hibernate_armed = cmd_op[eq_mode_pkg::FEAT_HIBERNATE];
  assign written_feature.low_frequency_select = cmd_op[eq_mode_pkg::FEAT_LOW_FREQ];
  assign written_feature.auto_sync = cmd_op[eq_mode_pkg::FEAT_AUTO_SYNC];
  assign written_feature.read_preamble_enable = cmd_op[eq_mode_pkg::FEAT_PREAMBLE];
  assign written_feature.half_command_ref = cmd_op[eq_mode_pkg::FEAT_HALF_CMD_REF];
  assign written_feature.half_data_ref = cmd_op[eq_mode_pkg::FEAT_HALF_DATA_REF];

  // Self refresh entry consumes an armed hibernate request
  wire hibernate_take = self_refresh_entry_in & feature_q.hibernate_armed;

  // A write in the same cycle as the entry wins over the self-clear
  always_comb begin
    next_feature = feature_q;
    if (hibernate_take) begin
      next_feature.hibernate_armed = 1'b0;
    end
    if (feat_write) begin
      next_feature = written_feature;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      feature_q <= '0;
    end else begin
      feature_q <= next_feature;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      feature_out <= '0;
    end else begin
      feature_out <= next_feature;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      hibernate_entry_out <= 1'b0;
    end else begin
      hibernate_entry_out <= hibernate_take;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Effective data input reference
  // Half mode masks the codes at the output only, so stored values survive.

  logic [125:0] next_effective_vref;
  logic [71:0] next_effective_feq;

  always_comb begin
    next_effective_vref = '0;
    for (int i = 0; i < eq_mode_pkg::PIN_COUNT; i++) begin
      next_effective_vref[i*7 +: 7] = next_feature.half_data_ref ?
        eq_mode_pkg::VREF_RESET : next_vref[i];
    end
  end

  always_comb begin
    next_effective_feq = '0;
    for (int i = 0; i < eq_mode_pkg::PIN_COUNT; i++) begin
      next_effective_feq[i*4 +: 4] = next_feature.half_data_ref ?
        eq_mode_pkg::FEQ_RESET : next_feq[i];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      half_data_ref_out <= 1'b0;
    end else begin
      half_data_ref_out <= next_feature.half_data_ref;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      data_input_reference_out <= '0;
    end else begin
      data_input_reference_out <= next_effective_vref;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      feedback_equalizer_out <= '0;
    end else begin
      feedback_equalizer_out <= next_effective_feq;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Undefined level flag
  // Level codes 96..127 are the controller's error; the code is still stored
  // and this flag reports whether any pin now holds one.

  logic [17:0] bad_pin;

  always_comb begin
    bad_pin = '0;
    for (int i = 0; i < eq_mode_pkg::PIN_COUNT; i++) begin
      bad_pin[i] = (next_vref[i][6:5] == eq_mode_pkg::VREF_UNDEFINED_TOP);
    end
  end

  // Split per byte to keep the reduction shallow
  wire bad_byte0 = |bad_pin[8:0];
  wire bad_byte1 = |bad_pin[17:9];

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      undefined_level_out <= 1'b0;
    end else begin
      undefined_level_out <= bad_byte0 | bad_byte1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read preamble

  read_preamble_gen u_preamble (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .enable_in(feature_q.read_preamble_enable),
    .burst_start_in(read_burst_start_in),
    .gapless_in(read_burst_gapless_in),
    .active_out(preamble_active_out),
    .inv_flag_n_out(preamble_inv_flag_n_out)
  );

  // Read inversion setting does not alter the preamble pins
  wire unused_read_inversion = read_inversion_in;

endmodule
`default_nettype wire

// file: receiver_eq_mode_registers_properties.sv
// Port-level assertions for the mode register block
`default_nettype none
module receiver_eq_mode_properties (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Inputs
  input wire eq_mode_pkg::mrs_cmd_s mrs_cmd_in,
  input wire logic self_refresh_entry_in,
  input wire logic read_burst_start_in,
  input wire logic read_burst_gapless_in,
  // Outputs
  input wire logic [125:0] vref_level_out,
  input wire logic [71:0] feedback_eq_out,
  input wire logic [3:0] transmit_eq_out,
  input wire logic [125:0] data_input_reference_out,
  input wire logic [71:0] feedback_equalizer_out,
  input wire eq_mode_pkg::feature_s feature_out,
  input wire logic hibernate_entry_out,
  input wire logic preamble_active_out,
  input wire logic preamble_inv_flag_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  wire [11:0] op = mrs_cmd_in.operand;
  wire [4:0] sub = op[11:7];
  wire vref_wr = mrs_cmd_in.valid && mrs_cmd_in.select == eq_mode_pkg::SEL_VREF_LEVEL;
  wire feq_wr = mrs_cmd_in.valid && mrs_cmd_in.select == eq_mode_pkg::SEL_FEEDBACK_EQ;
  wire feat_wr = mrs_cmd_in.valid && mrs_cmd_in.select == eq_mode_pkg::SEL_FEATURE;
  sequence armed_entry;
    self_refresh_entry_in && feature_out.hibernate_armed;
  endsequence
  sequence preamble_start;
    read_burst_start_in && !read_burst_gapless_in && feature_out.read_preamble_enable;
  endsequence
  a_vref_pin_zero: assert property (
    vref_wr && sub == 5'h00 |=> vref_level_out[6:0] == $past(op[6:0]))
    else $error("pin zero level not stored");
  a_vref_byte_one: assert property (
    vref_wr && sub == 5'h1F |=> vref_level_out[125:63] == {9{$past(op[6:0])}})
    else $error("byte one broadcast wrong");
  a_txeq_byte_zero: assert property (
    vref_wr && sub == 5'h0A |=> transmit_eq_out[1:0] == $past(op[1:0]) && $stable(vref_level_out))
    else $error("transmit eq byte zero wrong");
  a_feq_pin_zero: assert property (
    feq_wr && sub == 5'h00 |=> feedback_eq_out[3:0] == $past(op[3:0]))
    else $error("pin zero eq not stored");
  a_feq_reserved_sub: assert property (
    feq_wr && sub == 5'h0A |=> $stable(feedback_eq_out))
    else $error("reserved eq sub-address changed state");
  a_feature_fields: assert property (
    feat_wr |=> feature_out == {$past(op[1]), $past(op[3]), $past(op[4]), $past(op[5]),
      $past(op[6]), $past(op[7])})
    else $error("feature fields wrong");
  a_half_forces_mid: assert property (
    feature_out.half_data_ref |-> data_input_reference_out == '0 && feedback_equalizer_out == '0)
    else $error("half mode not applied");
  a_restore_stored: assert property (
    !feature_out.half_data_ref |-> data_input_reference_out == vref_level_out)
    else $error("stored levels not restored");
  a_hibernate_pulse: assert property (armed_entry |=> hibernate_entry_out)
    else $error("hibernate entry missing");
  a_hibernate_cause: assert property (
    hibernate_entry_out |-> $past(self_refresh_entry_in && feature_out.hibernate_armed))
    else $error("hibernate entry without cause");
  a_preamble_window: assert property (preamble_start |=> preamble_active_out [*4])
    else $error("preamble window short");
  a_preamble_flag_high: assert property (preamble_active_out |-> preamble_inv_flag_n_out)
    else $error("inversion flag low in preamble");
endmodule
`default_nettype wire

// file: host_controller_model.sv
// Memory controller model issuing mode register set commands
`default_nettype none
module host_controller_model #(
  parameter int SETTLE_CYCLES = 4
) (
  // Clock
  input wire logic sys_clk_in,
  // Command bus
  output var eq_mode_pkg::mrs_cmd_s mrs_cmd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial mrs_cmd_out = '0;
  // Callers keep level codes at or below 95 and eq codes small
  task automatic issue(input logic [3:0] sel, input logic [11:0] op);
    @(posedge sys_clk_in);
    mrs_cmd_out <= '{1'b1, sel, op};
    @(posedge sys_clk_in);
    // Idle bus shows inverted fields so a stale command cannot pass
    mrs_cmd_out <= '{1'b0, ~sel, ~op};
    if (sel != eq_mode_pkg::SEL_FEATURE) begin
      repeat (SETTLE_CYCLES) @(posedge sys_clk_in);
    end
  endtask
endmodule
`default_nettype wire

// file: receiver_eq_mode_registers_bench.sv
// Self-checking bench for the mode register block
`default_nettype none
module receiver_eq_mode_registers_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic self_refresh_entry_in = 1'b0;
  logic read_burst_start_in = 1'b0;
  logic read_burst_gapless_in = 1'b0;
  logic read_inversion_in = 1'b0;
  eq_mode_pkg::mrs_cmd_s mrs_cmd_in;
  logic [125:0] vref_level_out;
  logic [71:0] feedback_eq_out;
  logic [3:0] transmit_eq_out;
  logic half_data_ref_out;
  logic [125:0] data_input_reference_out;
  logic [71:0] feedback_equalizer_out;
  eq_mode_pkg::feature_s feature_out;
  logic hibernate_entry_out;
  logic undefined_level_out;
  logic preamble_active_out;
  logic preamble_inv_flag_n_out;
  int failures = 0;
  int samples_checked = 0;
  logic [125:0] exp_vref = '0;
  logic [71:0] exp_feq = '0;
  always #4 sys_clk_in = ~sys_clk_in;
  host_controller_model i_host (.sys_clk_in(sys_clk_in), .mrs_cmd_out(mrs_cmd_in));
  receiver_eq_mode_registers i_dut (.sys_clk_in, .sys_rst_in, .mrs_cmd_in,
    .self_refresh_entry_in, .read_burst_start_in, .read_burst_gapless_in, .read_inversion_in,
    .vref_level_out, .feedback_eq_out, .transmit_eq_out, .half_data_ref_out,
    .data_input_reference_out, .feedback_equalizer_out, .feature_out, .hibernate_entry_out,
    .undefined_level_out, .preamble_active_out, .preamble_inv_flag_n_out);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  function automatic logic [4:0] sub_of(input int p);
    return (p < 9) ? 5'(p) : 5'(p + 7);
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_vref;
    // Reverse pin order: result must not depend on write order
    for (int p = 17; p >= 0; p--) begin
      i_host.issue(eq_mode_pkg::SEL_VREF_LEVEL, {sub_of(p), 7'(p + 16)});
      exp_vref[7*p +: 7] = 7'(p + 16);
    end
    i_host.issue(eq_mode_pkg::SEL_VREF_LEVEL, {5'h09, 7'h5F});
    i_host.issue(eq_mode_pkg::SEL_VREF_LEVEL, {5'h1B, 7'h5F});
    i_host.issue(eq_mode_pkg::SEL_VREF_LEVEL, {5'h0A, 7'h02});
    i_host.issue(eq_mode_pkg::SEL_VREF_LEVEL, {5'h1A, 7'h03});
    @(negedge sys_clk_in);
    check(128'(vref_level_out), 128'(exp_vref));
    check(128'({undefined_level_out, transmit_eq_out}), 128'hE);
    i_host.issue(eq_mode_pkg::SEL_VREF_LEVEL, {5'h1F, 7'h33});
    for (int p = 9; p < 18; p++) exp_vref[7*p +: 7] = 7'h33;
    @(negedge sys_clk_in);
    check(128'(vref_level_out), 128'(exp_vref));
    $display("test vref done");
  endtask
  task automatic t_feq;
    for (int p = 0; p < 18; p++) begin
      i_host.issue(eq_mode_pkg::SEL_FEEDBACK_EQ, {sub_of(p), 3'h0, 4'(p)});
      exp_feq[4*p +: 4] = 4'(p);
    end
    i_host.issue(eq_mode_pkg::SEL_FEEDBACK_EQ, {5'h0A, 7'h05});
    @(negedge sys_clk_in);
    check(128'(feedback_eq_out), 128'(exp_feq));
    i_host.issue(eq_mode_pkg::SEL_FEEDBACK_EQ, {5'h0F, 7'h0C});
    for (int p = 0; p < 9; p++) exp_feq[4*p +: 4] = 4'hC;
    @(negedge sys_clk_in);
    check(128'(feedback_eq_out), 128'(exp_feq));
    $display("test eq done");
  endtask
  task automatic t_half;
    i_host.issue(eq_mode_pkg::SEL_FEATURE, 12'hFFD);
    @(negedge sys_clk_in);
    check(128'(feature_out), 128'h1F);
    check(128'({half_data_ref_out, feedback_equalizer_out}), 128'h1 << 72);
    check(128'(data_input_reference_out), 128'h0);
    check(128'(vref_level_out), 128'(exp_vref));
    i_host.issue(eq_mode_pkg::SEL_FEATURE, 12'h000);
    @(negedge sys_clk_in);
    check(128'(data_input_reference_out), 128'(exp_vref));
    check(128'(feedback_equalizer_out), 128'(exp_feq));
    $display("test half done");
  endtask
  task automatic t_hibernate;
    i_host.issue(eq_mode_pkg::SEL_FEATURE, 12'h002);
    @(negedge sys_clk_in);
    check(128'(feature_out), 128'h20);
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk_in);
      self_refresh_entry_in <= 1'b1;
      @(posedge sys_clk_in);
      self_refresh_entry_in <= 1'b0;
      @(negedge sys_clk_in);
      check(128'({hibernate_entry_out, feature_out}), 128'(i == 0) << 6);
    end
    $display("test hibernate done");
  endtask
  task automatic t_preamble;
    i_host.issue(eq_mode_pkg::SEL_FEATURE, 12'h020);
    for (int g = 1; g >= 0; g--) begin
      @(posedge sys_clk_in);
      read_burst_start_in <= 1'b1;
      read_burst_gapless_in <= 1'(g);
      read_inversion_in <= 1'(g);
      @(posedge sys_clk_in);
      read_burst_start_in <= 1'b0;
      for (int c = 0; c < 5; c++) begin
        @(negedge sys_clk_in);
        check(128'({preamble_active_out, preamble_inv_flag_n_out}),
          128'({g == 0 && c < 4, 1'b1}));
      end
    end
    $display("test preamble done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    @(negedge sys_clk_in);
    check(128'({vref_level_out, feature_out, preamble_inv_flag_n_out}), 128'h1);
    check(128'({hibernate_entry_out, undefined_level_out, transmit_eq_out}), 128'h0);
    t_vref;
    t_feq;
    t_half;
    t_hibernate;
    t_preamble;
    test_done;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge sys_clk_in);
    failures++;
    test_done;
  end
endmodule
bind receiver_eq_mode_registers receiver_eq_mode_properties i_props (.sys_clk_in, .sys_rst_in,
  .mrs_cmd_in, .self_refresh_entry_in, .read_burst_start_in, .read_burst_gapless_in,
  .vref_level_out, .feedback_eq_out, .transmit_eq_out, .data_input_reference_out,
  .feedback_equalizer_out, .feature_out, .hibernate_entry_out, .preamble_active_out,
  .preamble_inv_flag_n_out);
`default_nettype wire
